// *** src/port_strobe_handshake.sv ***
// Port-C strobe generator and external address driver.
// Assumes core access pulses are synchronous to ref_clk_i and one cycle wide;
// the port pins and strobe enable come from outside and are synchronised here.
module port_strobe_handshake
  import port_strobe_pkg::*;
#(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rstn_i,
  // Core side of the third gpio port
  input  wire logic              core_port_wr_i,
  input  wire logic [DATA_W-1:0] core_port_wdata_i,
  input  wire logic              core_port_rd_i,
  output logic      [DATA_W-1:0] core_port_rdata_o,
  // Control bit from the cpu control register
  input  wire logic              port_strobe_enable_i,
  // Third gpio port pins
  input  wire logic [DATA_W-1:0] third_gpio_port_in_i,
  output logic      [DATA_W-1:0] third_gpio_port_out_o,
  output logic      [DATA_W-1:0] third_gpio_port_oe_o,
  input  wire logic [DATA_W-1:0] third_gpio_port_dir_i,
  // External strobes, active low
  output logic                   rd_strobe_n_o,
  output logic                   wr_strobe_n_o,
  // External memory access through auto pointers
  input  wire logic              ext_acc_i,
  input  wire logic              ext_acc_wr_i,
  input  wire ptr_sel_t          ext_ptr_sel_i,
  input  wire logic [ADDR_W-1:0] auto_pointer_first_i,
  input  wire logic [ADDR_W-1:0] auto_pointer_second_i,
  output logic      [ADDR_W-1:0] ext_addr_o,
  output logic                   ext_addr_oe_o,
  output logic                   ext_rd_n_o,
  output logic                   ext_wr_n_o
);

  if (DATA_W < 1 || ADDR_W < 1) begin : g_bad_width
    $error("port_strobe_handshake: widths must be positive");
  end

  // Read data is latched at the read itself, so the lead must match the read delay
  if (SAMPLE_LEAD != RD_DELAY_CYC) begin : g_bad_lead
    $error("port_strobe_handshake: sample lead must equal the read strobe delay");
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [DATA_W-1:0] pin_s1_r;
  logic [DATA_W-1:0] pin_s2_r;
  logic              en_s1_r;
  logic              en_s2_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      en_s1_r  <= 1'b0;
      en_s2_r  <= 1'b0;
    end else begin
      pin_s1_r <= third_gpio_port_in_i;
      pin_s2_r <= pin_s1_r;
      en_s1_r  <= port_strobe_enable_i;
      en_s2_r  <= en_s1_r;
    end
  end

  // ************************************************************
  // Port data path
  // ************************************************************
  logic [DATA_W-1:0] out_r;
  logic [DATA_W-1:0] out_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    out_nxt   = out_r;
    rdata_nxt = rdata_r;
    if (core_port_wr_i) begin
      out_nxt = core_port_wdata_i;
    end
    // Latched at the read itself, three cycles before the strobe; the
    // strobe edge captures nothing so the far side may move data after it
    if (core_port_rd_i) begin
      rdata_nxt = pin_s2_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_r   <= DATA_W'(PORT_OUT_RST);
      rdata_r <= '0;
    end else begin
      out_r   <= out_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign third_gpio_port_out_o = out_r;
  assign third_gpio_port_oe_o  = third_gpio_port_dir_i;
  assign core_port_rdata_o     = rdata_r;

  // ************************************************************
  // Port strobes
  // ************************************************************
  logic wr_start;
  logic rd_start;
  logic port_wr_act;
  logic port_rd_act;

  assign wr_start = core_port_wr_i && en_s2_r;
  assign rd_start = core_port_rd_i && en_s2_r;

  strobe_timer #(
    .DELAY (WR_DELAY_CYC),
    .WIDTH (STB_WIDTH_CYC)
  ) u_wr_timer (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .start_i   (wr_start),
    .active_o  (port_wr_act),
    .busy_o    ()
  );

  strobe_timer #(
    .DELAY (RD_DELAY_CYC),
    .WIDTH (STB_WIDTH_CYC)
  ) u_rd_timer (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .start_i   (rd_start),
    .active_o  (port_rd_act),
    .busy_o    ()
  );

  // ************************************************************
  // External memory address
  // ************************************************************
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic              aoe_r;
  logic              aoe_nxt;
  logic              mrd_r;
  logic              mrd_nxt;
  logic              mwr_r;
  logic              mwr_nxt;

  // ext_acc_i is high for the whole (stretched) access cycle
  always_comb begin
    addr_nxt = addr_r;
    aoe_nxt  = 1'b0;
    mrd_nxt  = ext_acc_i && !ext_acc_wr_i;
    mwr_nxt  = ext_acc_i && ext_acc_wr_i;
    if (ext_acc_i) begin
      case (ext_ptr_sel_i)
        PTR_FIRST: begin
          addr_nxt = auto_pointer_first_i;
          aoe_nxt  = mrd_nxt || mwr_nxt;
        end
        PTR_SECOND: begin
          addr_nxt = auto_pointer_second_i;
          aoe_nxt  = 1'b1;
        end
        default: begin
          aoe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_r <= ADDR_W'(ADDR_RST);
      aoe_r  <= 1'b0;
      mrd_r  <= 1'b0;
      mwr_r  <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      aoe_r  <= aoe_nxt;
      mrd_r  <= mrd_nxt;
      mwr_r  <= mwr_nxt;
    end
  end

  assign ext_addr_o    = addr_r;
  assign ext_addr_oe_o = aoe_r;
  assign ext_rd_n_o    = ~mrd_r;
  assign ext_wr_n_o    = ~mwr_r;

  // Shared pins: a port strobe and a memory strobe both pull low
  assign rd_strobe_n_o = ~(port_rd_act || mrd_r);
  assign wr_strobe_n_o = ~(port_wr_act || mwr_r);

endmodule

// *** common/port_strobe_pkg.sv ***
// Constants and types for the port-C strobe and external address block.
// Assumes a single core clock; the core side raises one-cycle access pulses.
package port_strobe_pkg;

  // ************************************************************
  // Strobe timing, in core clock cycles
  // ************************************************************
  localparam int unsigned WR_DELAY_CYC  = 2;
  localparam int unsigned RD_DELAY_CYC  = 3;
  localparam int unsigned STB_WIDTH_CYC = 2;
  localparam int unsigned SAMPLE_LEAD   = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  PORT_OUT_RST  = 8'h00;
  localparam logic [15:0] ADDR_RST      = 16'h0000;

  typedef enum logic [1:0] {
    PTR_NONE,
    PTR_FIRST,
    PTR_SECOND
  } ptr_sel_t;

endpackage

// *** src/strobe_timer.sv ***
// One strobe generator: delay then a fixed-width active pulse.
// Assumes a one-cycle start pulse from logic on the same clock.
module strobe_timer
  import port_strobe_pkg::*;
#(
  parameter int unsigned DELAY = 2,
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // Control
  input  wire logic start_i,
  output logic      active_o,
  output logic      busy_o
);

  localparam int unsigned TOTAL = DELAY + WIDTH;
  localparam int unsigned CW    = $clog2(TOTAL + 1);

  if (WIDTH < 1 || DELAY < 1) begin : g_bad_timing
    $error("strobe_timer: DELAY and WIDTH must be at least one");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          act_r;
  logic          act_nxt;

  // A new start while running restarts the sequence; the core cannot
  // issue port accesses that close together in practice.
  always_comb begin
    cnt_nxt = cnt_r;
    if (start_i) begin
      cnt_nxt = CW'(TOTAL);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CW'(1);
    end
    // Active during the last WIDTH counts
    act_nxt = (cnt_nxt != '0) && (cnt_nxt <= CW'(WIDTH));
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  assign active_o = act_r;
  assign busy_o   = (cnt_r != '0);

endmodule

// *** tb/port_strobe_handshake_properties.sv ***
// Checker: port strobe and external address timing.
// Sees only the top ports; port and memory accesses are kept apart.
module port_strobe_handshake_chk
  import port_strobe_pkg::*;
#(
  parameter int unsigned DATA_W = 8,
  parameter int unsigned ADDR_W = 16
) (
  input wire logic              ref_clk_i,
  input wire logic              rstn_i,
  input wire logic              core_port_wr_i,
  input wire logic              core_port_rd_i,
  input wire logic [DATA_W-1:0] core_port_rdata_o,
  input wire logic              port_strobe_enable_i,
  input wire logic [DATA_W-1:0] third_gpio_port_in_i,
  input wire logic        rd_strobe_n_o,
  input wire logic        wr_strobe_n_o,
  input wire logic        ext_acc_i,
  input wire ptr_sel_t    ext_ptr_sel_i,
  input wire logic [ADDR_W-1:0] auto_pointer_second_i,
  input wire logic [ADDR_W-1:0] ext_addr_o,
  input wire logic        ext_addr_oe_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire en = port_strobe_enable_i, acc = ext_acc_i, rdn = rd_strobe_n_o, wrn = wr_strobe_n_o;
  // The design acts on the enable as it stood two edges earlier (two-flop synchroniser)
  a_wr_strobe_time: assert property (
    core_port_wr_i && en && $past(en, 2) && !acc |=> wrn [*2] ##1 !wrn [*2] ##1 wrn)
    else $error("wr strobe timing");
  a_rd_strobe_time: assert property (
    core_port_rd_i && en && $past(en, 2) && !acc |=> rdn [*3] ##1 !rdn [*2] ##1 rdn)
    else $error("rd strobe timing");
  a_strobe_off_quiet: assert property (
    (core_port_wr_i || core_port_rd_i) && !en && !$past(en, 2) && !acc |=> (rdn && wrn) [*6])
    else $error("strobe while disabled");
  a_rd_data_lead: assert property (
    core_port_rd_i |=> core_port_rdata_o == $past(third_gpio_port_in_i, 3))
    else $error("rd data sample");
  a_rd_no_capture: assert property (
    !rdn && !$past(core_port_rd_i) |-> $stable(core_port_rdata_o))
    else $error("rd strobe captured");
  a_first_ptr_gate: assert property (
    ext_addr_oe_o && $past(ext_ptr_sel_i) == PTR_FIRST |-> !(rdn && wrn))
    else $error("ptr1 addr outside strobe");
  a_second_ptr_hold: assert property (
    acc && ext_ptr_sel_i == PTR_SECOND
    |=> ext_addr_oe_o && ext_addr_o == $past(auto_pointer_second_i))
    else $error("ptr2 addr dropped");
  a_addr_idle_off: assert property (
    !acc || ext_ptr_sel_i == PTR_NONE |=> !ext_addr_oe_o)
    else $error("addr driven idle");
endmodule
bind port_strobe_handshake port_strobe_handshake_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (.*);

// *** tb/port_peer.sv ***
// Far-side peripheral: serves a byte stream, logs written bytes.
// Assumes active-low strobes on the core clock.
module port_peer (
  input  wire logic       ref_clk_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] out_i,
  output logic      [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  logic       rd_d;
  logic       wr_d;
  initial pin_o = 8'hA5;
  // Next byte only once the read strobe is low, so the core never samples a torn value
  always @(posedge ref_clk_i) begin
    rd_d <= rd_n_i;
    wr_d <= wr_n_i;
    if (rd_d && !rd_n_i) pin_o <= pin_o + 8'h3B;
    if (wr_d && !wr_n_i) q.push_back(out_i);
  end
endmodule

// *** tb/port_strobe_handshake_bench.sv ***
// Bench: random port accesses against an integer model, then memory accesses.
// Assumes the peer steps its byte by 3B on each read strobe.
module port_strobe_handshake_bench
  import port_strobe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 0, rstn_i = 0, core_port_wr_i = 0, core_port_rd_i = 0, ext_acc_i = 0;
  logic port_strobe_enable_i = 0, ext_acc_wr_i = 0, rd_strobe_n_o, wr_strobe_n_o;
  logic ext_addr_oe_o, ext_rd_n_o, ext_wr_n_o;
  logic [7:0] core_port_wdata_i = 0, third_gpio_port_dir_i = 8'h0F, core_port_rdata_o;
  logic [7:0] third_gpio_port_in_i, third_gpio_port_out_o, third_gpio_port_oe_o, wq[$];
  logic [15:0] auto_pointer_first_i = 0, auto_pointer_second_i = 0, ext_addr_o;
  ptr_sel_t ext_ptr_sel_i = PTR_NONE;
  int n_mismatch, comparisons, n_adv;
  port_strobe_handshake u_dut (.*);
  port_peer u_peer (.ref_clk_i, .rd_n_i(rd_strobe_n_o), .wr_n_i(wr_strobe_n_o),
                    .out_i(third_gpio_port_out_o), .pin_o(third_gpio_port_in_i));
  always #25 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // ****
  // Port access: enable settles past the synchroniser first
  // ****
  task automatic port_acc(input bit w);
    int dly;
    bit lo;
    dly = w ? int'(WR_DELAY_CYC) : int'(RD_DELAY_CYC);
    port_strobe_enable_i = 1'($urandom);
    core_port_wdata_i = 8'($urandom);
    third_gpio_port_dir_i = 8'($urandom);
    tick(5);
    chk(16'(third_gpio_port_oe_o), 16'(third_gpio_port_dir_i));
    if (w) core_port_wr_i = 1;
    else core_port_rd_i = 1;
    tick(1);
    core_port_wr_i = 0;
    core_port_rd_i = 0;
    if (w) chk(16'(third_gpio_port_out_o), 16'(core_port_wdata_i));
    else chk(16'(core_port_rdata_o), 16'(8'(8'hA5 + n_adv * 59)));
    if (w && port_strobe_enable_i) wq.push_back(core_port_wdata_i);
    if (!w && port_strobe_enable_i) n_adv++;
    // Strobe level in each cycle after the access, from the package timing
    for (int k = 1; k <= 8; k++) begin
      lo = port_strobe_enable_i && k > dly && k <= dly + int'(STB_WIDTH_CYC);
      chk(16'(w ? wr_strobe_n_o : rd_strobe_n_o), 16'(!lo));
      chk(16'(w ? rd_strobe_n_o : wr_strobe_n_o), 16'h0001);
      tick(1);
    end
    tick(2);
  endtask
  task automatic ext(input ptr_sel_t s, input bit w);
    ext_ptr_sel_i = s;
    ext_acc_wr_i = w;
    auto_pointer_first_i = 16'($urandom);
    auto_pointer_second_i = 16'($urandom);
    ext_acc_i = 1;
    tick(2 + $urandom % 4);
    chk(16'(ext_addr_oe_o), 16'(s != PTR_NONE));
    if (s == PTR_FIRST) chk(ext_addr_o, auto_pointer_first_i);
    if (s == PTR_SECOND) chk(ext_addr_o, auto_pointer_second_i);
    chk(16'({ext_rd_n_o, ext_wr_n_o}), 16'({w, !w}));
    chk(16'({rd_strobe_n_o, wr_strobe_n_o}), 16'({w, !w}));
    ext_acc_i = 0;
    tick(4);
    chk(16'(ext_addr_oe_o), 16'h0000);
    chk(16'({ext_rd_n_o, ext_wr_n_o, rd_strobe_n_o, wr_strobe_n_o}), 16'h000F);
  endtask
  initial begin
    void'($urandom(47026));
    tick(8);
    rstn_i = 1;
    tick(3);
    for (int i = 0; i < 24; i++) port_acc(1'($urandom));
    chk(16'(u_peer.q.size()), 16'(wq.size()));
    foreach (wq[k]) chk(16'(u_peer.q[k]), 16'(wq[k]));
    for (int s = 0; s < 6; s++) ext(ptr_sel_t'(s % 3), s > 2);
    close_out();
  end
  // Tests need about 22 us; over five times that means a hang
  initial begin
    #120us;
    n_mismatch++;
    close_out();
  end
endmodule
